// File: rtl/port_pins_ext_bus_mux.sv
// four port latches, pin buffers, external bus takeover and serial pins
//
// Function
// - input-only latch one selects analog, reset ones
// - latch zero gives digital input, never drives
// - 8-bit indirect move: mux port only, latch ones
// - pointer move or code read: both ports
// - external fetch: high port restored after access
// - fourth port alternate needs latch one, else low
// - fourth port alternate function bit assignments
// - input-only port feeds timer and slave select
// - latch write, read latch, read pin strobes
// - mux port open drain, push-pull under override
// - high port pull-up, push-pull under override
// - strong pull-up two periods on rising latch
// - spi owns fourth port bit three
// - serial pins open drain or push-pull by select
// - spi hysteresis path, i2c glitch filter
// - i2c master direct pin access by software
// - mux port address with strobe, then data
`timescale 1ns/1ps
module port_pins_ext_bus_mux (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] port_sel,
  input wire logic wr_latch,
  input wire logic rd_latch,
  input wire logic rd_pin,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic ext_req,
  input wire logic [1:0] ext_kind,
  input wire logic ext_write,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] ext_wdata,
  output logic addr_strobe,
  output logic [7:0] ext_rdata,
  input wire logic [7:0] mux_pin_in,
  output logic [7:0] mux_pin_out,
  output logic [7:0] mux_pin_oe,
  input wire logic [7:0] ain_pin_in,
  output logic [7:0] analog_sel,
  output logic third_timer_input,
  output logic third_timer_capture_trigger,
  output logic spi_slave_select_n,
  input wire logic [7:0] high_pin_in,
  output logic [7:0] high_pin_out,
  output logic [7:0] high_pin_oe,
  output logic [7:0] high_strong_pu,
  output logic [7:0] high_keeper,
  input wire logic [7:0] alt_pin_in,
  input wire logic [7:0] alt_func_out,
  output logic [7:0] alt_pin_out,
  output logic [7:0] alt_pin_oe,
  output logic [7:0] alt_strong_pu,
  output logic [7:0] alt_keeper,
  output logic [7:0] alt_func_in,
  input wire logic serial_spi_select_bit,
  input wire logic spi_miso_out,
  input wire logic spi_sclk_out,
  input wire logic spi_mosi_out,
  input wire logic i2c_master_sw,
  input wire logic i2c_sw_clk_bit,
  input wire logic i2c_sw_data_bit,
  input wire logic i2c_sw_data_oe,
  input wire logic i2c_hw_clk_out,
  input wire logic i2c_hw_data_out,
  input wire logic serial_clock_pin_in,
  input wire logic serial_data_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic serial_dual_pulldown,
  output logic [1:0] spi_pin_in,
  output logic [1:0] i2c_pin_in
);

  // ----------------------------------------------------------------
  // latches and bus sequencer
  // ----------------------------------------------------------------
  logic [7:0] mux_bus_port_latch_reg;
  logic [7:0] analog_input_port_latch_reg;
  logic [7:0] high_addr_port_latch_reg;
  logic [7:0] alt_function_port_latch_reg;
  logic [7:0] high_latch_next;
  logic [7:0] alt_latch_next;
  port_pins_pkg::bus_state_t state_reg;
  port_pins_pkg::bus_state_t state_next;
  logic [1:0] kind_reg;
  logic write_reg;

  function automatic logic hit(input logic [1:0] sel);
    hit = wr_latch && (port_sel == sel);
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      port_pins_pkg::BUS_IDLE: begin
        if (ext_req) begin
          state_next = port_pins_pkg::BUS_ADDR;
        end
      end
      port_pins_pkg::BUS_ADDR: begin
        state_next = port_pins_pkg::BUS_DATA;
      end
      port_pins_pkg::BUS_DATA: begin
        if (!ext_req) begin
          state_next = port_pins_pkg::BUS_IDLE;
        end
      end
      default: begin
        state_next = port_pins_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= port_pins_pkg::BUS_IDLE;
      kind_reg <= port_pins_pkg::KIND_RI;
      write_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == port_pins_pkg::BUS_IDLE && ext_req) begin
        kind_reg <= ext_kind;
        write_reg <= ext_write;
      end
    end
  end

  // mux port latch is wiped to ones by any external access
  always_ff @(posedge mclk) begin
    if (rst) begin
      mux_bus_port_latch_reg <= port_pins_pkg::LATCH_RESET;
    end else if (state_reg == port_pins_pkg::BUS_ADDR) begin
      mux_bus_port_latch_reg <= port_pins_pkg::MUX_FORCE;
    end else if (hit(port_pins_pkg::SEL_MUX)) begin
      mux_bus_port_latch_reg <= wr_data;
    end
  end

  assign high_latch_next = hit(port_pins_pkg::SEL_HIGH) ? wr_data :
    high_addr_port_latch_reg;
  assign alt_latch_next = hit(port_pins_pkg::SEL_ALT) ? wr_data :
    alt_function_port_latch_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      analog_input_port_latch_reg <= port_pins_pkg::LATCH_RESET;
      high_addr_port_latch_reg <= port_pins_pkg::LATCH_RESET;
      alt_function_port_latch_reg <= port_pins_pkg::LATCH_RESET;
    end else begin
      if (hit(port_pins_pkg::SEL_ANALOG)) begin
        analog_input_port_latch_reg <= wr_data;
      end
      high_addr_port_latch_reg <= high_latch_next;
      alt_function_port_latch_reg <= alt_latch_next;
    end
  end

  // ----------------------------------------------------------------
  // cpu read path
  // ----------------------------------------------------------------
  logic [7:0] alt_pin_view;
  assign alt_pin_view = serial_spi_select_bit ?
    {alt_pin_in[7:4], alt_function_port_latch_reg[3], alt_pin_in[2:0]} :
    alt_pin_in;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_latch) begin
      case (port_sel)
        port_pins_pkg::SEL_MUX: rd_data <= mux_bus_port_latch_reg;
        port_pins_pkg::SEL_ANALOG: rd_data <= analog_input_port_latch_reg;
        port_pins_pkg::SEL_HIGH: rd_data <= high_addr_port_latch_reg;
        default: rd_data <= alt_function_port_latch_reg;
      endcase
    end else if (rd_pin) begin
      case (port_sel)
        port_pins_pkg::SEL_MUX: rd_data <= mux_pin_in;
        port_pins_pkg::SEL_ANALOG: rd_data <= ain_pin_in;
        port_pins_pkg::SEL_HIGH: rd_data <= high_pin_in;
        default: rd_data <= alt_pin_view;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mux and high address port drivers
  // ----------------------------------------------------------------
  logic high_override;
  assign high_override = state_reg != port_pins_pkg::BUS_IDLE &&
    kind_reg != port_pins_pkg::KIND_RI;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mux_pin_out <= 8'h00;
      mux_pin_oe <= 8'h00;
      addr_strobe <= 1'b0;
      ext_rdata <= 8'h00;
    end else begin
      addr_strobe <= state_reg == port_pins_pkg::BUS_ADDR;
      case (state_reg)
        port_pins_pkg::BUS_ADDR: begin
          mux_pin_out <= addr_lo;
          mux_pin_oe <= 8'hFF;
        end
        port_pins_pkg::BUS_DATA: begin
          mux_pin_out <= ext_wdata;
          mux_pin_oe <= write_reg ? 8'hFF : 8'h00;
          ext_rdata <= mux_pin_in;
        end
        default: begin
          mux_pin_out <= 8'h00;
          mux_pin_oe <= ~mux_bus_port_latch_reg;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      high_pin_out <= 8'h00;
      high_pin_oe <= 8'h00;
      high_keeper <= 8'h00;
    end else if (high_override) begin
      high_pin_out <= addr_hi;
      high_pin_oe <= 8'hFF;
      high_keeper <= 8'h00;
    end else begin
      high_pin_out <= 8'h00;
      high_pin_oe <= ~high_addr_port_latch_reg;
      high_keeper <= high_addr_port_latch_reg & high_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // strong pull-up pulses, two clock periods per rising latch bit
  // ----------------------------------------------------------------
  logic [7:0] high_pu_old_reg;
  logic [7:0] alt_pu_old_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      high_strong_pu <= 8'h00;
      high_pu_old_reg <= 8'h00;
      alt_strong_pu <= 8'h00;
      alt_pu_old_reg <= 8'h00;
    end else begin
      high_strong_pu <= (high_latch_next & ~high_addr_port_latch_reg) |
        (high_strong_pu & ~high_pu_old_reg);
      high_pu_old_reg <= high_strong_pu & ~high_pu_old_reg;
      alt_strong_pu <= (alt_latch_next & ~alt_function_port_latch_reg) |
        (alt_strong_pu & ~alt_pu_old_reg);
      alt_pu_old_reg <= alt_strong_pu & ~alt_pu_old_reg;
    end
  end

  // ----------------------------------------------------------------
  // alternate function port and input-only port
  // ----------------------------------------------------------------
  logic [7:0] alt_level;
  assign alt_level = alt_function_port_latch_reg & alt_func_out;

  always_ff @(posedge mclk) begin
    if (rst) begin
      alt_pin_out <= 8'h00;
      alt_pin_oe <= 8'h00;
      alt_keeper <= 8'h00;
      alt_func_in <= 8'hFF;
    end else begin
      alt_pin_out <= 8'h00;
      alt_pin_oe <= ~alt_level;
      alt_keeper <= alt_level & alt_pin_in;
      alt_func_in <= alt_pin_in;
      if (serial_spi_select_bit) begin
        alt_pin_out[port_pins_pkg::ALT_SPI_BIT] <= spi_miso_out;
        alt_pin_oe[port_pins_pkg::ALT_SPI_BIT] <= 1'b1;
        alt_keeper[port_pins_pkg::ALT_SPI_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      analog_sel <= port_pins_pkg::LATCH_RESET;
      third_timer_input <= 1'b0;
      third_timer_capture_trigger <= 1'b0;
      spi_slave_select_n <= 1'b1;
    end else begin
      analog_sel <= analog_input_port_latch_reg;
      third_timer_input <= ain_pin_in[port_pins_pkg::AIN_TIMER_BIT] &
        ~analog_input_port_latch_reg[port_pins_pkg::AIN_TIMER_BIT];
      third_timer_capture_trigger <= ain_pin_in[port_pins_pkg::AIN_TRIG_BIT] &
        ~analog_input_port_latch_reg[port_pins_pkg::AIN_TRIG_BIT];
      spi_slave_select_n <= ain_pin_in[port_pins_pkg::AIN_SS_BIT] |
        analog_input_port_latch_reg[port_pins_pkg::AIN_SS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // serial pins: drivers and input conditioning
  // ----------------------------------------------------------------
  logic clk_src;
  logic data_src;
  logic data_en;
  logic [1:0] raw_in;
  logic [1:0] flt_cnt_reg [2];

  assign clk_src = i2c_master_sw ? i2c_sw_clk_bit : i2c_hw_clk_out;
  assign data_src = i2c_master_sw ? i2c_sw_data_bit : i2c_hw_data_out;
  assign data_en = !i2c_master_sw || i2c_sw_data_oe;
  assign raw_in = {serial_data_pin_in, serial_clock_pin_in};

  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= 1'b0;
      serial_dual_pulldown <= 1'b1;
    end else if (serial_spi_select_bit) begin
      serial_clock_pin_out <= spi_sclk_out;
      serial_clock_pin_oe <= 1'b1;
      serial_data_pin_out <= spi_mosi_out;
      serial_data_pin_oe <= 1'b1;
      serial_dual_pulldown <= 1'b0;
    end else begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= ~clk_src;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= data_en & ~data_src;
      serial_dual_pulldown <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      spi_pin_in <= 2'h3;
      i2c_pin_in <= 2'h3;
      flt_cnt_reg[0] <= 2'h0;
      flt_cnt_reg[1] <= 2'h0;
    end else begin
      spi_pin_in <= raw_in;
      for (int i = 0; i < 2; i++) begin
        if (raw_in[i] == i2c_pin_in[i]) begin
          flt_cnt_reg[i] <= 2'h0;
        end else if (flt_cnt_reg[i] == 2'(port_pins_pkg::GLITCH_CYC - 1)) begin
          i2c_pin_in[i] <= raw_in[i];
          flt_cnt_reg[i] <= 2'h0;
        end else begin
          flt_cnt_reg[i] <= flt_cnt_reg[i] + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence rise_high0_s;
    hit(port_pins_pkg::SEL_HIGH) && wr_data[0] &&
      !high_addr_port_latch_reg[0];
  endsequence

  sequence pulse_two_s;
    high_strong_pu[0] [*2] ##1 !high_strong_pu[0];
  endsequence

  analog_default_a: assert property (@(posedge mclk)
    $fell(rst) |-> analog_input_port_latch_reg == 8'hFF)
    else $error("input-only latch not ones after reset");

  ri_keeps_high_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == port_pins_pkg::BUS_ADDR && kind_reg == port_pins_pkg::KIND_RI
    |=> high_pin_oe == ~$past(high_addr_port_latch_reg))
    else $error("high port disturbed by indirect move");

  mux_forced_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == port_pins_pkg::BUS_ADDR && !hit(port_pins_pkg::SEL_MUX)
    |=> mux_bus_port_latch_reg == 8'hFF && mux_pin_oe == 8'hFF)
    else $error("mux latch not forced to ones");

  high_restore_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == port_pins_pkg::BUS_IDLE && !ext_req
    |=> high_pin_out == 8'h00 && high_pin_oe == ~$past(high_addr_port_latch_reg))
    else $error("high port not restored after access");

  alt_gate_a: assert property (@(posedge mclk) disable iff (rst)
    !alt_function_port_latch_reg[0] |=> alt_pin_oe[0] && !alt_pin_out[0])
    else $error("alternate pin not held low");

  read_latch_a: assert property (@(posedge mclk) disable iff (rst)
    rd_latch && port_sel == port_pins_pkg::SEL_HIGH
    |=> rd_data == $past(high_addr_port_latch_reg))
    else $error("read latch returned wrong value");

  addr_phase_a: assert property (@(posedge mclk) disable iff (rst)
    state_reg == port_pins_pkg::BUS_ADDR
    |=> addr_strobe && mux_pin_out == $past(addr_lo) && mux_pin_oe == 8'hFF)
    else $error("address phase not driven");

  strong_pu_a: assert property (@(posedge mclk) disable iff (rst)
    rise_high0_s |=> pulse_two_s)
    else $error("strong pull-up not two periods");

  i2c_drive_a: assert property (@(posedge mclk) disable iff (rst)
    !serial_spi_select_bit |=> !serial_clock_pin_out && serial_dual_pulldown)
    else $error("serial pin not open drain in i2c mode");

  glitch_reject_a: assert property (@(posedge mclk) disable iff (rst)
    $stable(i2c_pin_in[1]) && raw_in[1] != i2c_pin_in[1] && flt_cnt_reg[1] == 0
    |=> $stable(i2c_pin_in[1]))
    else $error("single cycle glitch passed filter");

endmodule

// File: rtl/port_pins_pkg.sv
// shared constants and types for the port pin and external bus block
package port_pins_pkg;
  // port select codes on the cpu latch interface
  localparam logic [1:0] SEL_MUX = 2'h0;
  localparam logic [1:0] SEL_ANALOG = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [1:0] SEL_ALT = 2'h3;
  // latch reset value and external access force value
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] MUX_FORCE = 8'hFF;
  // external access kinds
  localparam logic [1:0] KIND_RI = 2'h0;
  localparam logic [1:0] KIND_DATA_POINTER_REG = 2'h1;
  localparam logic [1:0] KIND_FETCH = 2'h2;
  // alternate function bit positions
  localparam int ALT_SPI_BIT = 3;
  localparam int AIN_TIMER_BIT = 0;
  localparam int AIN_TRIG_BIT = 1;
  localparam int AIN_SS_BIT = 5;
  // timing
  localparam int CLK_NS = 40;
  localparam int STRONG_PU_CYC = 2;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  // external bus sequencer
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ADDR = 3'b010,
    BUS_DATA = 3'b100
  } bus_state_t;
endpackage

// File: test/ext_mem_model.sv
// external memory and board pull-ups on the multiplexed port
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic mclk,
  input wire logic addr_strobe,
  input wire logic rd_en,
  input wire logic [7:0] mux_pin_out,
  input wire logic [7:0] mux_pin_oe,
  output logic [7:0] mux_pin_in
);
  logic [7:0] addr_q = 8'h00;
  logic seen = 1'b0;
  logic drive;
  // address byte captured by the strobe
  always @(posedge mclk) begin
    if (addr_strobe) begin
      addr_q <= mux_pin_out;
    end
    seen <= addr_strobe | (seen & rd_en);
  end
  // memory drives only once the port has floated
  assign drive = rd_en & seen & (mux_pin_oe == 8'h00);
  // released lines sit at the board pull-up level
  assign mux_pin_in = drive ? (addr_q ^ 8'hA5) :
    ((mux_pin_oe & mux_pin_out) | ~mux_pin_oe);
endmodule

// File: test/tb_port_pins_ext_bus_mux.sv
// self-checking bench for the port pins and external bus block
`timescale 1ns/1ps
module tb_port_pins_ext_bus_mux;
  logic mclk = 0, rst = 1, wr_latch = 0, rd_latch = 0, rd_pin = 0;
  logic [1:0] port_sel = 0, ext_kind = 0;
  logic [7:0] wr_data = 0, rd_data, addr_lo = 0, addr_hi = 0;
  logic ext_req = 0, ext_write = 0, addr_strobe;
  logic [7:0] ext_wdata = 0, ext_rdata, mux_pin_in, mux_pin_out, mux_pin_oe;
  logic [7:0] ain_pin_in = 0, analog_sel, high_pin_in, high_pin_out;
  logic [7:0] high_pin_oe, high_strong_pu, alt_pin_in, alt_func_out = 8'hFF;
  logic [7:0] alt_pin_out, alt_pin_oe, alt_strong_pu, alt_func_in, v;
  logic [7:0] hk, ak;
  logic tt_in, tt_cap, ss_n, spi_sel = 0, miso = 0, sclk = 0, mosi = 0;
  logic i2c_sw = 0, sw_clk = 1, sw_dat = 1, sw_oe = 0, sc_in = 1, sd_in = 1;
  logic sc_out, sc_oe, sd_out, sd_oe, dual_pd;
  logic [1:0] spi_pin_in, i2c_pin_in;
  logic [7:0] lat [4];
  int err_total = 0, n_checks = 0;
  always #20 mclk = ~mclk;
  function automatic logic [7:0] lvl(input logic [7:0] o, e);
    return (e & o) | ~e;
  endfunction
  assign high_pin_in = lvl(high_pin_out, high_pin_oe);
  assign alt_pin_in = lvl(alt_pin_out, alt_pin_oe);
  ext_mem_model mem (.mclk(mclk), .addr_strobe(addr_strobe),
    .rd_en(ext_req & ~ext_write), .mux_pin_out(mux_pin_out),
    .mux_pin_oe(mux_pin_oe), .mux_pin_in(mux_pin_in));
  port_pins_ext_bus_mux uut (.mclk(mclk), .rst(rst), .port_sel(port_sel),
    .wr_latch(wr_latch), .rd_latch(rd_latch), .rd_pin(rd_pin),
    .wr_data(wr_data), .rd_data(rd_data), .ext_req(ext_req),
    .ext_kind(ext_kind), .ext_write(ext_write), .addr_lo(addr_lo),
    .addr_hi(addr_hi), .ext_wdata(ext_wdata), .addr_strobe(addr_strobe),
    .ext_rdata(ext_rdata), .mux_pin_in(mux_pin_in),
    .mux_pin_out(mux_pin_out), .mux_pin_oe(mux_pin_oe),
    .ain_pin_in(ain_pin_in), .analog_sel(analog_sel),
    .third_timer_input(tt_in), .third_timer_capture_trigger(tt_cap),
    .spi_slave_select_n(ss_n), .high_pin_in(high_pin_in),
    .high_pin_out(high_pin_out), .high_pin_oe(high_pin_oe),
    .high_strong_pu(high_strong_pu), .high_keeper(hk),
    .alt_pin_in(alt_pin_in), .alt_func_out(alt_func_out),
    .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe),
    .alt_strong_pu(alt_strong_pu), .alt_keeper(ak),
    .alt_func_in(alt_func_in), .serial_spi_select_bit(spi_sel),
    .spi_miso_out(miso), .spi_sclk_out(sclk), .spi_mosi_out(mosi),
    .i2c_master_sw(i2c_sw), .i2c_sw_clk_bit(sw_clk),
    .i2c_sw_data_bit(sw_dat), .i2c_sw_data_oe(sw_oe),
    .i2c_hw_clk_out(1'b1), .i2c_hw_data_out(1'b1),
    .serial_clock_pin_in(sc_in), .serial_data_pin_in(sd_in),
    .serial_clock_pin_out(sc_out), .serial_clock_pin_oe(sc_oe),
    .serial_data_pin_out(sd_out), .serial_data_pin_oe(sd_oe),
    .serial_dual_pulldown(dual_pd), .spi_pin_in(spi_pin_in),
    .i2c_pin_in(i2c_pin_in));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    port_sel = p;
    wr_data = d;
    wr_latch = 1;
    cyc(1);
    wr_latch = 0;
    lat[p] = d;
  endtask
  task automatic rd(input logic [1:0] p, input logic pin);
    port_sel = p;
    rd_latch = !pin;
    rd_pin = pin;
    cyc(1);
    rd_latch = 0;
    rd_pin = 0;
    cyc(1);
    v = rd_data;
  endtask
  task automatic ext(input logic [1:0] k, input logic w,
                     input logic [7:0] lo, hi);
    ext_kind = k;
    ext_write = w;
    addr_lo = lo;
    addr_hi = hi;
    ext_wdata = ~lo;
    ext_req = 1;
    cyc(2);
    chk({7'h0, addr_strobe}, 8'h01);
    chk(mux_pin_out, lo);
    chk(mux_pin_oe, 8'hFF);
    chk(high_pin_oe, (k == port_pins_pkg::KIND_RI) ? ~lat[2] : 8'hFF);
    if (k != port_pins_pkg::KIND_RI) chk(high_pin_out, hi);
    cyc(1);
    chk({7'h0, addr_strobe}, 8'h00);
    cyc(2);
    chk(mux_pin_oe, w ? 8'hFF : 8'h00);
    if (w) chk(mux_pin_out, ~lo);
    else chk(ext_rdata, lo ^ 8'hA5);
    ext_req = 0;
    cyc(3);
    rd(port_pins_pkg::SEL_MUX, 0);
    chk(v, port_pins_pkg::MUX_FORCE);
    lat[0] = 8'hFF;
    rd(port_pins_pkg::SEL_HIGH, 0);
    chk(v, lat[2]);
    chk(high_pin_oe, ~lat[2]);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    err_total++;
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(16));
    cyc(6);
    rst = 0;
    for (int p = 0; p < 4; p++) begin
      rd(p[1:0], 0);
      chk(v, port_pins_pkg::LATCH_RESET);
      lat[p] = v;
    end
    chk(analog_sel, 8'hFF);
    chk(mux_pin_oe, 8'h00);
    chk(high_strong_pu, 8'h00);
    for (int i = 0; i < 40; i++) begin
      ain_pin_in = 8'($urandom);
      alt_func_out = 8'($urandom);
      wr(i[1:0], (i < 4) ? 8'h00 : (i < 8) ? 8'hFF : 8'($urandom));
      cyc(3);
      rd(i[1:0], 0);
      chk(v, lat[i % 4]);
      rd(i[1:0], 1);
      case (i % 4)
        0: chk(v, lat[0]);
        1: chk(v, ain_pin_in);
        2: chk(v, lat[2]);
        default: chk(v, lat[3] & alt_func_out);
      endcase
      chk(mux_pin_oe, ~lat[0]);
      chk(alt_pin_in, lat[3] & alt_func_out);
      chk(alt_func_in, lat[3] & alt_func_out);
      chk(hk, lat[2]);
      chk(ak, lat[3] & alt_func_out);
      chk(analog_sel, lat[1]);
      chk({6'h0, tt_cap, tt_in}, {6'h0, ain_pin_in[1:0] & ~lat[1][1:0]});
      chk({7'h0, ss_n}, {7'h0, ain_pin_in[5] | lat[1][5]});
    end
    for (int p = 2; p < 4; p++) begin
      wr(p[1:0], 8'h00);
      cyc(3);
      wr(p[1:0], 8'h5A);
      chk(p == 2 ? high_strong_pu : alt_strong_pu, 8'h5A);
      cyc(1);
      chk(p == 2 ? high_strong_pu : alt_strong_pu, 8'h5A);
      cyc(1);
      chk(p == 2 ? high_strong_pu : alt_strong_pu, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      wr(port_pins_pkg::SEL_MUX, 8'($urandom));
      ext(2'(i / 2), i[0], 8'($urandom), 8'($urandom));
      cyc(1);
    end
    chk({7'h0, dual_pd}, 8'h01);
    sd_in = 0;
    cyc(1);
    sd_in = 1;
    cyc(4);
    chk({6'h0, i2c_pin_in}, 8'h03);
    sd_in = 0;
    cyc(4);
    chk({6'h0, i2c_pin_in}, 8'h01);
    chk({6'h0, spi_pin_in}, 8'h01);
    i2c_sw = 1;
    sw_oe = 1;
    for (int b = 0; b < 4; b++) begin
      sw_clk = b[0];
      sw_dat = b[1];
      cyc(3);
      chk(lvl({6'h0, sd_out, sc_out}, {6'h0, sd_oe, sc_oe}),
          {6'h3F, b[1:0]});
    end
    spi_sel = 1;
    wr(port_pins_pkg::SEL_ALT, 8'h00);
    for (int m = 0; m < 2; m++) begin
      miso = m[0];
      sclk = m[0];
      mosi = ~m[0];
      cyc(3);
      v = lvl(alt_pin_out, alt_pin_oe);
      chk({7'h0, v[3]}, {7'h0, miso});
      chk({7'h0, dual_pd}, 8'h00);
      chk({4'h0, sd_out, sc_out, sd_oe, sc_oe}, {4'h0, ~miso, miso, 2'h3});
    end
    rd(port_pins_pkg::SEL_ALT, 1);
    chk({7'h0, v[3]}, 8'h00);
    final_report();
  end
endmodule
